/* File: rtl/seq_pkg.sv */
// Package: register map, field layout, timing constants and carrier types for the lead/lag sequencer.
package seq_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TICK_S = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
   localparam int unsigned RESTART_MIN = 5;
   localparam logic [15:0] RESTART_SECS = 16'(RESTART_MIN * 60);
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SENSOR_OFS = 8'h04;
   localparam logic [7:0] SETPT_OFS = 8'h08;
   localparam logic [7:0] HYST_OFS = 8'h0C;
   localparam logic [7:0] DELAY_OFS = 8'h10;
   localparam logic [7:0] ROT_OFS = 8'h14;
   localparam logic [7:0] STAT_OFS = 8'h18;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h1C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
   localparam logic [7:0] RUN1_OFS = 8'h24;
   localparam logic [7:0] RUN2_OFS = 8'h28;
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTL_SENS_VALID = 0;
   localparam int CTL_SCHED_VALID = 1;
   localparam int CTL_EQ_VALID = 2;
   localparam int CTL_ROTATING = 3;
   localparam int CTL_AUTO_RST = 4;
   localparam int CTL_ROTATE_NOW = 5;
   localparam int CTL_FORCE1_EN = 6;
   localparam int CTL_FORCE1_VAL = 7;
   localparam int CTL_FORCE2_EN = 8;
   localparam int CTL_FORCE2_VAL = 9;
   localparam int CTL_SENS_OOR = 10;
   localparam int CTL_DOW_EN = 11;
   localparam int CTL_DOM_EN = 12;
   localparam int CTL_HRS_EN = 13;
   // Interrupt status bits.
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_NORMAL = 1;
   localparam int IRQ_ROTATE = 2;
   localparam int IRQ_W = 3;
   // ----------------------------------------
   // Reset values and seconds per hour
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] DELAY_RST = 16'h000A;
   localparam logic [31:0] ROT_RST = 32'h0000_0000;
   localparam logic [15:0] SETPT_LO_RST = 16'h0000;
   localparam logic [15:0] SETPT_HI_RST = 16'hFFFF;
   localparam logic [15:0] HYST_RST = 16'h0000;
   localparam logic [31:0] RUN_RST = 32'h0000_0000;
   localparam logic [31:0] SECS_PER_HOUR = 32'h0000_0E10;

   typedef enum logic [2:0] {
      S_IDLE, S_CONFIRM, S_RUN, S_FAILED
   } seq_state_t;

   typedef struct packed {
      logic status1;
      logic status2;
      logic occupied;
      logic equip_on;
      logic dow_hit;
      logic dom_hit;
   } field_in_t;

   typedef struct packed {
      logic drive1;
      logic drive2;
   } field_out_t;
endpackage

/* File: rtl/lead_lag_seq.sv */
// Lead/lag two-device sequencer with APB registers, start confirmation and failover.
//
// Operation
// - Drive two devices as lead and lag.
// - Fixed mode: lag only backs up failed lead.
// - Manual rotate request swaps lead and lag.
// - Rotating mode swaps on day or hours.
// - Demand precedence: sensor, schedule, equipment status.
// - Auto-restart independent of demand source.
// - Sensor outside setpoints starts lead.
// - Stop only inside hysteresis band, else hold.
// - Schedule occupied runs lead, else stopped.
// - Equipment status on runs lead, else off.
// - Confirm start after delay, else try lag.
// - Both failed: outputs off until manual rotate request or auto-restart; alarm only when lag fails start confirmation.
// - Auto-restart retries every five minutes.
// - Running lead drops out: start lag.
// - Forced value overrides computed output.
// - Sensor out of range falls back to schedule.
// - Alarm clears on later success, readable flag.
`timescale 1ns/1ps
`default_nettype none
module lead_lag_seq #(
   // Cycles per one-second tick; only a bench has reason to shorten it.
   parameter int unsigned TICK_DIV = seq_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Field side
   input wire seq_pkg::field_in_t field_in,
   output seq_pkg::field_out_t field_out,
   // Interrupt
   output logic irq
);
   import seq_pkg::*;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   field_in_t sync1_r, sync2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= field_in;
         sync2_r <= sync1_r;
      end
   end

   // ----------------------------------------
   // One-second tick
   // ----------------------------------------
   logic [23:0] div_r;
   logic tick_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r == 24'(TICK_DIV - 1));
         div_r <= (div_r == 24'(TICK_DIV - 1)) ? '0 : div_r + 24'h000001;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] ctrl_r, rot_r, run1_r, run2_r;
   logic [15:0] sensor_r, lo_r, hi_r, hyst_r, delay_r;
   logic [IRQ_W-1:0] ista_r, imask_r;
   logic wr_en, rd_en, mapped, rotate_pulse;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign mapped = (paddr <= RUN2_OFS) && (paddr[1:0] == 2'b00);
   assign rotate_pulse = wr_en && (paddr == CTRL_OFS) && pwdata[CTL_ROTATE_NOW];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         sensor_r <= '0;
         lo_r <= SETPT_LO_RST;
         hi_r <= SETPT_HI_RST;
         hyst_r <= HYST_RST;
         delay_r <= DELAY_RST;
         rot_r <= ROT_RST;
         imask_r <= '0;
      end else if (wr_en) begin
         case (paddr)
            CTRL_OFS: ctrl_r <= pwdata & ~(32'h1 << CTL_ROTATE_NOW);
            SENSOR_OFS: sensor_r <= pwdata[15:0];
            SETPT_OFS: begin
               lo_r <= pwdata[15:0];
               hi_r <= pwdata[31:16];
            end
            HYST_OFS: hyst_r <= pwdata[15:0];
            DELAY_OFS: delay_r <= pwdata[15:0];
            ROT_OFS: rot_r <= pwdata;
            IRQ_MASK_OFS: imask_r <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Demand selection
   // ----------------------------------------
   logic sens_ok, demand, ana_dem_r;
   logic [16:0] lo_band, hi_band;
   // Out-of-range sensor is treated as absent.
   assign sens_ok = ctrl_r[CTL_SENS_VALID] && !ctrl_r[CTL_SENS_OOR];
   assign lo_band = {1'b0, lo_r} + {1'b0, hyst_r};
   assign hi_band = {1'b0, hi_r} - {1'b0, hyst_r};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ana_dem_r <= 1'b0;
      end else if (sensor_r > hi_r || sensor_r < lo_r) begin
         ana_dem_r <= 1'b1;
      end else if ({1'b0, sensor_r} >= lo_band && {1'b0, sensor_r} <= hi_band) begin
         ana_dem_r <= 1'b0;
      end
   end
   always_comb begin
      if (sens_ok) begin
         demand = ana_dem_r;
      end else if (ctrl_r[CTL_SCHED_VALID]) begin
         demand = sync2_r.occupied;
      end else if (ctrl_r[CTL_EQ_VALID]) begin
         demand = sync2_r.equip_on;
      end else begin
         demand = 1'b0;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   seq_state_t state_r;
   logic lead_r, on_lag_r, alarm_r, drv1, drv2, act_status;
   logic [15:0] tmr_r;
   logic [31:0] since_rot_r;
   logic auto_rot, do_rot, rot_edge_r, dow_d_r, dom_d_r;
   logic ev_alarm, ev_normal;
   // lead_r = 0 means device 1 leads.
   assign act_status = (lead_r ^ on_lag_r) ? sync2_r.status2 : sync2_r.status1;
   // Calendar or runtime trigger in rotating mode.
   assign auto_rot = ctrl_r[CTL_ROTATING] && (
      (ctrl_r[CTL_DOW_EN] && sync2_r.dow_hit && !dow_d_r) ||
      (ctrl_r[CTL_DOM_EN] && sync2_r.dom_hit && !dom_d_r) ||
      (ctrl_r[CTL_HRS_EN] && !rot_edge_r && rot_r != '0 && since_rot_r >= rot_r * SECS_PER_HOUR));
   assign ev_alarm = (state_r == S_CONFIRM) && demand && tick_r && tmr_r <= 16'h0001 && !act_status && on_lag_r;
   assign ev_normal = alarm_r && (state_r == S_CONFIRM) && act_status;
   // The runtime trigger is a level, so it waits out the cycle that clears its count, or it would swap twice.
   assign do_rot = rotate_pulse || (auto_rot && state_r != S_CONFIRM);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dow_d_r <= 1'b0;
         dom_d_r <= 1'b0;
      end else begin
         dow_d_r <= sync2_r.dow_hit;
         dom_d_r <= sync2_r.dom_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lead_r <= 1'b0;
         rot_edge_r <= 1'b0;
      end else begin
         rot_edge_r <= do_rot;
         // Fixed mode swaps only on manual request.
         if (do_rot) begin
            lead_r <= ~lead_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         on_lag_r <= 1'b0;
         tmr_r <= '0;
      end else begin
         case (state_r)
            S_IDLE: begin
               on_lag_r <= 1'b0;
               if (demand) begin
                  state_r <= S_CONFIRM;
                  tmr_r <= delay_r;
               end
            end
            S_CONFIRM: begin
               if (!demand) begin
                  state_r <= S_IDLE;
               end else if (act_status) begin
                  state_r <= S_RUN;
               end else if (tick_r) begin
                  if (tmr_r > 16'h0001) begin
                     tmr_r <= tmr_r - 16'h0001;
                  end else if (!on_lag_r) begin
                     on_lag_r <= 1'b1;
                     tmr_r <= delay_r;
                  end else begin
                     state_r <= S_FAILED;
                     tmr_r <= RESTART_SECS;
                  end
               end
            end
            S_RUN: begin
               if (!demand) begin
                  state_r <= S_IDLE;
               end else if (!act_status && !on_lag_r) begin
                  on_lag_r <= 1'b1;
                  state_r <= S_CONFIRM;
                  tmr_r <= delay_r;
               end else if (!act_status) begin
                  state_r <= S_FAILED;
                  tmr_r <= RESTART_SECS;
               end
            end
            S_FAILED: begin
               // Retry does not look at the demand source.
               if (rotate_pulse) begin
                  state_r <= S_IDLE;
               end else if (ctrl_r[CTL_AUTO_RST] && tick_r) begin
                  if (tmr_r > 16'h0001) begin
                     tmr_r <= tmr_r - 16'h0001;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Alarm flag set when lag fails start confirmation, cleared on success.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_r <= 1'b0;
      end else if (ev_alarm) begin
         alarm_r <= 1'b1;
      end else if (ev_normal) begin
         alarm_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run1_r <= RUN_RST;
         run2_r <= RUN_RST;
         since_rot_r <= RUN_RST;
      end else begin
         if (rot_edge_r) begin
            since_rot_r <= RUN_RST;
         end else if (tick_r && (drv1 || drv2)) begin
            since_rot_r <= since_rot_r + 32'h1;
         end
         if (tick_r && sync2_r.status1) begin
            run1_r <= run1_r + 32'h1;
         end
         if (tick_r && sync2_r.status2) begin
            run2_r <= run2_r + 32'h1;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic active;
   assign active = (state_r == S_CONFIRM) || (state_r == S_RUN);
   // Only the active device of the pair is driven.
   assign drv1 = active && ((lead_r ^ on_lag_r) == 1'b0);
   assign drv2 = active && ((lead_r ^ on_lag_r) == 1'b1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         field_out <= '0;
      end else begin
         field_out.drive1 <= ctrl_r[CTL_FORCE1_EN] ? ctrl_r[CTL_FORCE1_VAL] : drv1;
         field_out.drive2 <= ctrl_r[CTL_FORCE2_EN] ? ctrl_r[CTL_FORCE2_VAL] : drv2;
      end
   end

   // ----------------------------------------
   // Interrupts and read path
   // ----------------------------------------
   logic [IRQ_W-1:0] iset;
   assign iset = {rot_edge_r, ev_normal, ev_alarm};
   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ista_r <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == IRQ_STAT_OFS) begin
            ista_r <= (ista_r & ~pwdata[IRQ_W-1:0]) | iset;
         end else begin
            ista_r <= ista_r | iset;
         end
         irq <= |(ista_r & imask_r);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               CTRL_OFS: prdata <= ctrl_r;
               SENSOR_OFS: prdata <= {16'h0000, sensor_r};
               SETPT_OFS: prdata <= {hi_r, lo_r};
               HYST_OFS: prdata <= {16'h0000, hyst_r};
               DELAY_OFS: prdata <= {16'h0000, delay_r};
               ROT_OFS: prdata <= rot_r;
               STAT_OFS: prdata <= {22'h0, tmr_r[6:0], alarm_r, lead_r, on_lag_r};
               IRQ_STAT_OFS: prdata <= {29'h0, ista_r};
               IRQ_MASK_OFS: prdata <= {29'h0, imask_r};
               RUN1_OFS: prdata <= run1_r;
               RUN2_OFS: prdata <= run2_r;
               default: prdata <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_force_one: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[CTL_FORCE1_EN] |=> field_out.drive1 == $past(ctrl_r[CTL_FORCE1_VAL]))
      else $error("Forced value not applied to output one.");
   a_failed_off: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_FAILED |-> !drv1 && !drv2)
      else $error("Device driven while both failed.");
   a_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
      ev_alarm |=> alarm_r && state_r == S_FAILED)
      else $error("Alarm not raised on double failure.");
   a_one_drive: assert property (@(posedge pclk) disable iff (!presetn)
      !(drv1 && drv2))
      else $error("Both devices driven at once.");
   a_rotate_swap: assert property (@(posedge pclk) disable iff (!presetn)
      rotate_pulse |=> lead_r != $past(lead_r))
      else $error("Manual rotate did not swap roles.");
   a_fixed_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[CTL_ROTATING] && !rotate_pulse |=> $stable(lead_r))
      else $error("Lead changed in fixed mode.");
   a_lead_drop: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_RUN && demand && !act_status && !on_lag_r |=> on_lag_r && state_r == S_CONFIRM)
      else $error("Lag not started after lead dropped out.");
   a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
      tick_r |=> !tick_r [*8])
      else $error("Second tick repeats too soon.");
   c_failover: cover property (@(posedge pclk) disable iff (!presetn) state_r == S_CONFIRM && on_lag_r);
   c_alarm: cover property (@(posedge pclk) disable iff (!presetn) ev_alarm);
   c_normal: cover property (@(posedge pclk) disable iff (!presetn) ev_normal);
endmodule
`default_nettype wire

/* File: test/dev_pair_model.sv */
// Behavioural model of the two field devices with on/off status feedback.
`timescale 1ns/1ps
`default_nettype none
module dev_pair_model #(
   parameter int START_CYC = 3
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Drive commands and failure selects
   input wire seq_pkg::field_out_t drives,
   input wire logic [1:0] broken,
   // Status feedback
   output logic status1,
   output logic status2
);
   import seq_pkg::*;
   int cnt1;
   int cnt2;
   // ----------------------------------------
   // Start and run behaviour
   // ----------------------------------------
   // A broken device never reports running, so start confirmation has something to catch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt1 <= 0;
         cnt2 <= 0;
         status1 <= 1'b0;
         status2 <= 1'b0;
      end else begin
         cnt1 <= drives.drive1 ? ((cnt1 < START_CYC) ? cnt1 + 1 : cnt1) : 0;
         cnt2 <= drives.drive2 ? ((cnt2 < START_CYC) ? cnt2 + 1 : cnt2) : 0;
         status1 <= drives.drive1 && !broken[1] && (cnt1 >= START_CYC);
         status2 <= drives.drive2 && !broken[0] && (cnt2 >= START_CYC);
      end
   end
endmodule
`default_nettype wire

/* File: test/lead_lag_seq_tb_top.sv */
// Self-checking bench for the lead/lag sequencer: registers, demand sources, overrides and rotation.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module lead_lag_seq_tb_top;
   import seq_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam logic [31:0] B_SENS = 32'h0000_0001 << CTL_SENS_VALID;
   localparam logic [31:0] B_SCHED = 32'h0000_0001 << CTL_SCHED_VALID;
   localparam logic [31:0] B_EQ = 32'h0000_0001 << CTL_EQ_VALID;
   localparam logic [31:0] B_ROT = 32'h0000_0001 << CTL_ROTATING;
   localparam logic [31:0] B_NOW = 32'h0000_0001 << CTL_ROTATE_NOW;
   localparam logic [31:0] B_F1 = 32'h0000_0001 << CTL_FORCE1_EN;
   localparam logic [31:0] B_F2 = 32'h0000_0001 << CTL_FORCE2_EN;
   localparam logic [31:0] B_F2V = 32'h0000_0001 << CTL_FORCE2_VAL;
   localparam logic [31:0] B_OOR = 32'h0000_0001 << CTL_SENS_OOR;
   localparam logic [31:0] B_DOW = 32'h0000_0001 << CTL_DOW_EN;
   localparam logic [31:0] B_DOM = 32'h0000_0001 << CTL_DOM_EN;
   localparam logic [31:0] B_AR = 32'h0000_0001 << CTL_AUTO_RST;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   field_in_t field_in;
   field_out_t field_out;
   logic st1;
   logic st2;
   logic occ = 1'b0;
   logic eqon = 1'b0;
   logic dow = 1'b0;
   logic dom = 1'b0;
   logic [1:0] broken = 2'b00;
   logic [31:0] rdat;
   logic rerr;
   int error_cnt = 0;
   int tests_run = 0;
   logic [15:0] sv [5] = '{16'h00FA, 16'h00C3, 16'h0096, 16'h0069, 16'h0032};
   logic [1:0] so [5] = '{2'b10, 2'b10, 2'b00, 2'b00, 2'b10};

   always #50 pclk = ~pclk;
   assign field_in = '{status1: st1, status2: st2, occupied: occ, equip_on: eqon, dow_hit: dow, dom_hit: dom};

   lead_lag_seq #(.TICK_DIV(20)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .field_in(field_in), .field_out(field_out), .irq(irq)
   );
   dev_pair_model devs_u (
      .pclk(pclk), .presetn(presetn), .drives(field_out), .broken(broken),
      .status1(st1), .status2(st2)
   );
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(a, 1'b0, 32'h0000_0000);
      `CHECK(rdat & m, e)
   endtask
   task automatic wait_out(input logic [1:0] e);
      int n;
      n = 0;
      while (field_out !== e && n < 40) begin
         @(posedge pclk);
         n++;
      end
      `CHECK(field_out, e)
   endtask
   // Settles for longer than the input sync and drive latency before looking.
   task automatic hold_out(input logic [1:0] e);
      repeat (30) @(posedge pclk);
      `CHECK(field_out, e)
   endtask
   task automatic pulse_day(input logic which);
      if (which) dom <= 1'b1; else dow <= 1'b1;
      @(posedge pclk);
      dom <= 1'b0;
      dow <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask
   task automatic test_end(input string name);
      $display("test %s done, mismatches so far %0d", name, error_cnt);
   endtask
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk(CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST);
      chk(SETPT_OFS, 32'hFFFF_FFFF, {SETPT_HI_RST, SETPT_LO_RST});
      chk(HYST_OFS, 32'hFFFF_FFFF, {16'h0000, HYST_RST});
      chk(DELAY_OFS, 32'hFFFF_FFFF, {16'h0000, DELAY_RST});
      chk(ROT_OFS, 32'hFFFF_FFFF, ROT_RST);
      chk(STAT_OFS, 32'h0000_0007, 32'h0000_0000);
      chk(IRQ_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
      chk(RUN1_OFS, 32'hFFFF_FFFF, RUN_RST);
      chk(RUN2_OFS, 32'hFFFF_FFFF, RUN_RST);
      wr(8'h2C, 32'hFFFF_FFFF);
      `CHECK(rerr, 1'b1)
      apb(8'h06, 1'b0, 32'h0000_0000);
      `CHECK({rerr, rdat}, 33'h1_0000_0000)
      test_end("registers");
      wr(CTRL_OFS, B_EQ);
      eqon <= 1'b1;
      wait_out(2'b10);
      hold_out(2'b10);
      eqon <= 1'b0;
      wait_out(2'b00);
      wr(CTRL_OFS, B_EQ | B_SCHED);
      eqon <= 1'b1;
      hold_out(2'b00);
      occ <= 1'b1;
      wait_out(2'b10);
      occ <= 1'b0;
      wait_out(2'b00);
      test_end("status_and_schedule");
      wr(SETPT_OFS, 32'h00C8_0064);
      wr(HYST_OFS, 32'h0000_000A);
      wr(SENSOR_OFS, 32'h0000_0096);
      wr(CTRL_OFS, B_SENS | B_SCHED | B_EQ);
      occ <= 1'b1;
      hold_out(2'b00);
      for (int i = 0; i < 5; i++) begin
         wr(SENSOR_OFS, {16'h0000, sv[i]});
         hold_out(so[i]);
      end
      wr(SENSOR_OFS, 32'h0000_0096);
      hold_out(2'b00);
      wr(CTRL_OFS, B_SENS | B_SCHED | B_EQ | B_OOR);
      hold_out(2'b10);
      occ <= 1'b0;
      hold_out(2'b00);
      test_end("sensor");
      occ <= 1'b1;
      wr(CTRL_OFS, B_SCHED | B_F1 | B_F2 | B_F2V);
      hold_out(2'b01);
      wr(CTRL_OFS, B_SCHED);
      hold_out(2'b10);
      occ <= 1'b0;
      hold_out(2'b00);
      // A three-second delay at twenty cycles a tick: failover lands between 44 and 64 cycles after demand.
      wr(DELAY_OFS, 32'h0000_0003);
      broken <= 2'b10;
      occ <= 1'b1;
      hold_out(2'b10);
      repeat (40) @(posedge pclk);
      `CHECK(field_out, 2'b01)
      chk(STAT_OFS, 32'h0000_0007, 32'h0000_0001);
      occ <= 1'b0;
      broken <= 2'b00;
      wait_out(2'b00);
      occ <= 1'b1;
      hold_out(2'b10);
      broken <= 2'b10;
      wait_out(2'b01);
      occ <= 1'b0;
      wait_out(2'b00);
      broken <= 2'b11;
      occ <= 1'b1;
      repeat (140) @(posedge pclk);
      `CHECK(field_out, 2'b00)
      chk(STAT_OFS, 32'h0000_0004, 32'h0000_0004);
      chk(IRQ_STAT_OFS, 32'h0000_0007, 32'h0000_0001);
      hold_out(2'b00);
      // The retry counts 300 ticks from here, so the restart lands 5981 to 6000 cycles later.
      wr(CTRL_OFS, B_SCHED | B_AR);
      broken <= 2'b00;
      repeat (5800) @(posedge pclk);
      `CHECK(field_out, 2'b00)
      repeat (400) @(posedge pclk);
      `CHECK(field_out, 2'b10)
      chk(STAT_OFS, 32'h0000_0004, 32'h0000_0000);
      chk(IRQ_STAT_OFS, 32'h0000_0007, 32'h0000_0003);
      wr(IRQ_STAT_OFS, 32'h0000_0007);
      occ <= 1'b0;
      wait_out(2'b00);
      test_end("force_and_confirm");
      eqon <= 1'b0;
      wr(CTRL_OFS, B_EQ | B_NOW);
      chk(CTRL_OFS, B_NOW, 32'h0000_0000);
      chk(STAT_OFS, 32'h0000_0002, 32'h0000_0002);
      chk(IRQ_STAT_OFS, 32'h0000_0007, 32'h0000_0004);
      `CHECK(irq, 1'b0)
      wr(IRQ_MASK_OFS, 32'h0000_0004);
      repeat (3) @(posedge pclk);
      `CHECK(irq, 1'b1)
      eqon <= 1'b1;
      wait_out(2'b01);
      eqon <= 1'b0;
      wait_out(2'b00);
      wr(IRQ_STAT_OFS, 32'h0000_0004);
      repeat (3) @(posedge pclk);
      `CHECK(irq, 1'b0)
      wr(CTRL_OFS, B_EQ | B_DOW);
      pulse_day(1'b0);
      chk(STAT_OFS, 32'h0000_0002, 32'h0000_0002);
      wr(CTRL_OFS, B_EQ | B_ROT | B_DOW);
      pulse_day(1'b0);
      chk(STAT_OFS, 32'h0000_0002, 32'h0000_0000);
      wr(CTRL_OFS, B_EQ | B_ROT | B_DOM);
      pulse_day(1'b1);
      chk(STAT_OFS, 32'h0000_0002, 32'h0000_0002);
      `CHECK(irq, 1'b1)
      wr(CTRL_OFS, B_EQ | B_ROT | B_NOW);
      chk(STAT_OFS, 32'h0000_0002, 32'h0000_0000);
      test_end("rotation");
      conclude();
   end
endmodule
`undef CHECK
`default_nettype wire
